// ### rtl/dma_acq_pkg.sv
// constants and types shared by the idle and bus-acquire front end
package dma_acq_pkg;
	// ------------------------------------------------------------
	// register map, byte addresses on the wishbone bus
	// ------------------------------------------------------------
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_MASK = 8'h04;
	localparam logic [7:0] ADR_SWREQ = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_MODE_BASE = 8'h10;
	localparam int ADR_WORD_LSB = 2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_LEGACY_BIT = 0;
	localparam int CTRL_MEMCOPY_BIT = 1;
	localparam int CTRL_ACTLOW_BIT = 2;
	localparam int CTRL_SWRST_BIT = 8;
	localparam int MODE_MEMCOPY_BIT = 0;
	localparam int MODE_TYPE_LSB = 6;
	localparam int MODE_W = 8;
	localparam logic [1:0] MODE_TYPE_CASCADE = 2'h3;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_HREQ_BIT = 4;
	localparam int STAT_SERVED_LSB = 8;
	localparam int STAT_VALID_LSB = 16;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic CTRL_LEGACY_RST = 1'h0;
	localparam logic CTRL_MEMCOPY_RST = 1'h0;
	localparam logic CTRL_ACTLOW_RST = 1'h0;
	localparam logic [MODE_W-1:0] MODE_RST = 8'h00;

	typedef enum logic [3:0] {
		idle_state = 4'h1,
		bus_acquire_state = 4'h2,
		io_transfer_first_state = 4'h4,
		mem_copy_first_state = 4'h8
	} fsm_state_t;
endpackage

// ### rtl/dma_fsm_idle_bus_acquire.sv
// idle and bus-acquire front end of the dma transfer state machine, with wishbone registers
// Notes on behaviour
// - hardware reset puts the state machine in idle.
// - registers accept host writes while idle.
// - stay idle until an unmasked request; then raise hold request and go acquire.
// - all state machine outputs inactive while idle.
// - software reset returns to idle only in legacy mode.
// - acquire keeps hold request up until hold acknowledge is sampled high.
// - registers still accept host writes during bus acquire.
// - on acknowledge go to io first state, or memory copy first state.
// - legacy memory copy: command enable, channel 0 request, encoder grants channel 0.
// - extended memory copy: bit 0 of the served channel's mode register.
// - served request dropped and nothing else pending: back to idle.
// - served request held or another pending: proceed to a first transfer state.
// - only requests passing polarity, mask and mode checks start hold request.
// - served channel in cascade mode abandons acquisition, back to idle.
`timescale 1ns/1ps
module dma_fsm_idle_bus_acquire
	import dma_acq_pkg::*;
#(
	parameter int NCH = 4,
	parameter int CH_W = (NCH > 1) ? $clog2(NCH) : 1
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [WB_DAT_W-1:0] wb_dat_i,
	output logic [WB_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NCH-1:0] dreq_i,
	input wire logic hlda_i,
	input wire logic xfer_done_i,
	output logic hreq_o,
	output logic io_first_o,
	output logic mem_first_o,
	output logic [CH_W-1:0] served_chan_o,
	output logic [NCH-1:0] grant_o
);
	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic mode_hit(input logic [WB_ADR_W-1:0] adr, input int ch);
		mode_hit = adr[WB_ADR_W-1:ADR_WORD_LSB] ==
			(ADR_MODE_BASE[WB_ADR_W-1:ADR_WORD_LSB] + (WB_ADR_W-ADR_WORD_LSB)'(ch));
	endfunction

	function automatic logic word_hit(input logic [WB_ADR_W-1:0] adr, input logic [7:0] off);
		word_hit = adr[WB_ADR_W-1:ADR_WORD_LSB] == off[WB_ADR_W-1:ADR_WORD_LSB];
	endfunction

	fsm_state_t state_r, state_nxt;
	logic [CH_W-1:0] served_r, served_nxt, pick_idx, cur_chan;
	logic [WB_DAT_W-1:0] dat_r, rd_val;
	logic [MODE_W-1:0] mode_r [NCH];
	logic [NCH-1:0] mask_r, swreq_r, cascade, level, valid, pick_grant;
	logic ack_r, legacy_r, memcopy_en_r, act_low_r;
	logic wr_go, swrst, served_live, others_pending, keep, served_cascade, mem_detect;

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	// one wait state: ack rises the cycle after the strobe, the write lands on the ack edge
	assign wr_go = ack_r & wb_cyc_i & wb_stb_i & wb_we_i;
	assign swrst = wr_go & wb_sel_i[1] & wb_dat_i[CTRL_SWRST_BIT] & word_hit(wb_adr_i, ADR_CTRL);
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
	end

	always_comb
	begin
		rd_val = '0;
		if (word_hit(wb_adr_i, ADR_CTRL))
		begin
			rd_val[CTRL_LEGACY_BIT] = legacy_r;
			rd_val[CTRL_MEMCOPY_BIT] = memcopy_en_r;
			rd_val[CTRL_ACTLOW_BIT] = act_low_r;
		end
		else if (word_hit(wb_adr_i, ADR_MASK))
			rd_val[NCH-1:0] = mask_r;
		else if (word_hit(wb_adr_i, ADR_SWREQ))
			rd_val[NCH-1:0] = swreq_r;
		else if (word_hit(wb_adr_i, ADR_STATUS))
		begin
			rd_val[STAT_STATE_LSB +: 4] = state_r;
			rd_val[STAT_HREQ_BIT] = hreq_o;
			rd_val[STAT_SERVED_LSB +: CH_W] = served_r;
			rd_val[STAT_VALID_LSB +: NCH] = valid;
		end
		for (int c = 0; c < NCH; c++)
		begin
			if (mode_hit(wb_adr_i, c))
				rd_val[MODE_W-1:0] = mode_r[c];
		end
	end

	// unmapped addresses are acked and read as zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= '0;
		else if (wb_cyc_i & wb_stb_i & ~ack_r & ~wb_we_i)
			dat_r <= rd_val;
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// writes are taken in every state, idle and bus acquire included
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			legacy_r <= CTRL_LEGACY_RST;
			memcopy_en_r <= CTRL_MEMCOPY_RST;
			act_low_r <= CTRL_ACTLOW_RST;
		end
		else if (wr_go & wb_sel_i[0] & word_hit(wb_adr_i, ADR_CTRL))
		begin
			legacy_r <= wb_dat_i[CTRL_LEGACY_BIT];
			memcopy_en_r <= wb_dat_i[CTRL_MEMCOPY_BIT];
			act_low_r <= wb_dat_i[CTRL_ACTLOW_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_r <= '1;
			swreq_r <= '0;
		end
		else if (wr_go & wb_sel_i[0])
		begin
			if (word_hit(wb_adr_i, ADR_MASK))
				mask_r <= wb_dat_i[NCH-1:0];
			if (word_hit(wb_adr_i, ADR_SWREQ))
				swreq_r <= wb_dat_i[NCH-1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_mode
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					mode_r[g] <= MODE_RST;
				else if (wr_go & wb_sel_i[0] & mode_hit(wb_adr_i, g))
					mode_r[g] <= wb_dat_i[MODE_W-1:0];
			end
			assign cascade[g] = mode_r[g][MODE_TYPE_LSB +: 2] == MODE_TYPE_CASCADE;
		end
	endgenerate

	// ------------------------------------------------------------
	// request qualification and priority
	// ------------------------------------------------------------
	req_qualify #(.NCH(NCH)) u_qual (
		.dreq_i(dreq_i),
		.swreq_i(swreq_r),
		.mask_i(mask_r),
		.cascade_i(cascade),
		.legacy_i(legacy_r),
		.act_low_i(act_low_r),
		.level_o(level),
		.valid_o(valid)
	);

	prio_pick #(.NCH(NCH), .CH_W(CH_W)) u_pick (
		.req_i(valid),
		.grant_o(pick_grant),
		.idx_o(pick_idx)
	);

	assign served_live = valid[served_r];
	assign others_pending = |(valid & ~(NCH'(1) << served_r));
	assign keep = served_live | others_pending;
	assign served_cascade = cascade[served_r];
	// a dropped served request hands over to the next pending channel
	assign cur_chan = served_live ? served_r : pick_idx;
	assign mem_detect = legacy_r ?
		(memcopy_en_r & level[0] & pick_grant[0]) :
		mode_r[cur_chan][MODE_MEMCOPY_BIT];

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		served_nxt = served_r;
		unique case (state_r)
			idle_state:
			begin
				served_nxt = '0;
				if (|valid)
				begin
					state_nxt = bus_acquire_state;
					served_nxt = pick_idx;
				end
			end
			bus_acquire_state:
			begin
				if (served_cascade)
					state_nxt = idle_state;
				else if (!keep)
					state_nxt = idle_state;
				else
				begin
					served_nxt = cur_chan;
					if (hlda_i)
						state_nxt = mem_detect ? mem_copy_first_state : io_transfer_first_state;
				end
			end
			io_transfer_first_state, mem_copy_first_state:
			begin
				if (xfer_done_i)
					state_nxt = idle_state;
			end
			default:
				state_nxt = idle_state;
		endcase
		if (swrst && legacy_r)
			state_nxt = idle_state;
		if (state_nxt == idle_state)
			served_nxt = '0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= idle_state;
			served_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			served_r <= served_nxt;
		end
	end

	// hold stays up from acquire through the handed-off transfer
	assign hreq_o = state_r != idle_state;
	assign io_first_o = state_r == io_transfer_first_state;
	assign mem_first_o = state_r == mem_copy_first_state;
	assign served_chan_o = served_r;
	assign grant_o = (state_r == idle_state) ? '0 : (NCH'(1) << served_r);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_reset_idle;
		@(posedge clk_i) disable iff (rst_i) $past(rst_i) |-> state_r == idle_state;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
	property p_idle_start;
		@(posedge clk_i) disable iff (rst_i)
			(state_r == idle_state && |valid && !(swrst && legacy_r))
			|=> state_r == bus_acquire_state && hreq_o;
	endproperty
	a_idle_start: assert property (p_idle_start) else $error("idle ignored valid request");
	property p_idle_quiet;
		@(posedge clk_i) disable iff (rst_i)
			state_r == idle_state |-> !hreq_o && !io_first_o && !mem_first_o && grant_o == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("output active in idle");
	property p_swrst_legacy;
		@(posedge clk_i) disable iff (rst_i) (swrst && legacy_r) |=> state_r == idle_state;
	endproperty
	a_swrst_legacy: assert property (p_swrst_legacy) else $error("soft reset ignored");
	property p_swrst_ext;
		@(posedge clk_i) disable iff (rst_i)
			(swrst && !legacy_r && (io_first_o || mem_first_o) && !xfer_done_i) |=> $stable(state_r);
	endproperty
	a_swrst_ext: assert property (p_swrst_ext) else $error("soft reset acted in extended");
	property p_hold_wait;
		@(posedge clk_i) disable iff (rst_i)
			(state_r == bus_acquire_state && !hlda_i && keep && !served_cascade
			&& !(swrst && legacy_r)) |=> state_r == bus_acquire_state && hreq_o;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("left acquire without ack");
	property p_grant_path;
		@(posedge clk_i) disable iff (rst_i)
			(state_r == bus_acquire_state && hlda_i && keep && !served_cascade
			&& !(swrst && legacy_r))
			|=> (mem_first_o == $past(mem_detect)) && (io_first_o == !$past(mem_detect));
	endproperty
	a_grant_path: assert property (p_grant_path) else $error("wrong first state");
	property p_legacy_memcopy;
		@(posedge clk_i) disable iff (rst_i)
			(legacy_r && state_r == bus_acquire_state && hlda_i && keep && !served_cascade
			&& !swrst) |=> mem_first_o == $past(memcopy_en_r && level[0] && valid[0]);
	endproperty
	a_legacy_memcopy: assert property (p_legacy_memcopy) else $error("legacy copy wrong");
	property p_drop_idle;
		@(posedge clk_i) disable iff (rst_i)
			(state_r == bus_acquire_state && !keep) |=> state_r == idle_state;
	endproperty
	a_drop_idle: assert property (p_drop_idle) else $error("dropped request kept");
	property p_hreq_cause;
		@(posedge clk_i) disable iff (rst_i) $rose(hreq_o) |-> $past(|valid);
	endproperty
	a_hreq_cause: assert property (p_hreq_cause) else $error("hold without request");
	property p_cascade_idle;
		@(posedge clk_i) disable iff (rst_i)
			(state_r == bus_acquire_state && served_cascade) |=> state_r == idle_state;
	endproperty
	a_cascade_idle: assert property (p_cascade_idle) else $error("cascade not abandoned");
	property p_mask_write;
		@(posedge clk_i) disable iff (rst_i)
			(wr_go && wb_sel_i[0] && word_hit(wb_adr_i, ADR_MASK)
			&& (state_r == idle_state || state_r == bus_acquire_state))
			|=> mask_r == $past(wb_dat_i[NCH-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");
endmodule

// ### rtl/prio_pick.sv
// fixed priority encoder, channel 0 highest
`timescale 1ns/1ps
module prio_pick
#(
	parameter int NCH = 4,
	parameter int CH_W = (NCH > 1) ? $clog2(NCH) : 1
)
(
	input wire logic [NCH-1:0] req_i,
	output logic [NCH-1:0] grant_o,
	output logic [CH_W-1:0] idx_o
);
	always_comb
	begin
		grant_o = '0;
		idx_o = '0;
		for (int i = NCH - 1; i >= 0; i--)
		begin
			if (req_i[i])
			begin
				grant_o = '0;
				grant_o[i] = 1'b1;
				idx_o = CH_W'(i);
			end
		end
	end
endmodule

// ### rtl/req_qualify.sv
// per-channel request qualification: polarity, software request, mask, mode
`timescale 1ns/1ps
module req_qualify
	import dma_acq_pkg::*;
#(
	parameter int NCH = 4
)
(
	input wire logic [NCH-1:0] dreq_i,
	input wire logic [NCH-1:0] swreq_i,
	input wire logic [NCH-1:0] mask_i,
	input wire logic [NCH-1:0] cascade_i,
	input wire logic legacy_i,
	input wire logic act_low_i,
	output logic [NCH-1:0] level_o,
	output logic [NCH-1:0] valid_o
);
	// active-low requests exist only in legacy mode; extended mode is active high
	genvar c;
	generate
		for (c = 0; c < NCH; c++)
		begin : g_ch
			assign level_o[c] = dreq_i[c] ^ (legacy_i & act_low_i);
			assign valid_o[c] = (level_o[c] | swreq_i[c]) & ~mask_i[c] & ~cascade_i[c];
		end
	endgenerate
endmodule

// ### verif/dma_fsm_idle_bus_acquire_tb_top.sv
// self-checking bench for the idle and bus-acquire front end
`timescale 1ns/1ps
module dma_fsm_idle_bus_acquire_tb_top;
	import dma_acq_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, dreq = 4'h0, dly = 4'h0;
	logic [31:0] dat = 32'h0;
	logic hlda, done = 1'b0, hen = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, hreq_o, io_first_o, mem_first_o;
	logic [1:0] served_chan_o;
	logic [3:0] grant_o;
	logic [31:0] expq[$];
	int mismatches = 0, n_checks = 0;

	dma_fsm_idle_bus_acquire #(.NCH(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dreq_i(dreq), .hlda_i(hlda),
		.xfer_done_i(done), .hreq_o(hreq_o), .io_first_o(io_first_o),
		.mem_first_o(mem_first_o), .served_chan_o(served_chan_o), .grant_o(grant_o));
	hold_host_model host_u (.clk_i(clk_i), .rst_i(rst_i), .hreq_i(hreq_o), .en_i(hen),
		.dly_i(dly), .hlda_o(hlda));

	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	task end_sim;
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one classic cycle; held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(1'b0, a, 32'h0, 4'hF);
	endtask

	// read data is compared against the oldest note when ack is seen
	logic ack_q = 1'b0;
	always @(posedge clk_i)
	begin
		ack_q <= wb_ack_o;
		if (ack_q === 1'b1)
			chk(wb_ack_o, 1'b0);
		if (wb_ack_o === 1'b1 && stb && !we)
		begin
			if (expq.size() == 0)
				chk(32'hDEAD, 32'h0);
			else
				chk(wb_dat_o, expq.pop_front());
		end
	end

	// raise requests, let the host grant, and land in a first state
	task reach(input logic [3:0] r, input logic m);
		dreq <= r;
		dly <= 4'($urandom_range(0, 7));
		hen <= 1'b1;
		for (int i = 0; i < 40 && (io_first_o | mem_first_o) !== 1'b1; i++)
			tick(1);
		chk(mem_first_o, m);
		chk(io_first_o, !m);
		chk(hreq_o, 1'b1);
	endtask

	task finish;
		dreq <= 4'h0;
		done <= 1'b1;
		hen <= 1'b0;
		tick(1);
		done <= 1'b0;
		tick(2);
		chk({hreq_o, io_first_o, mem_first_o, grant_o}, 32'h0);
	endtask

	task wait_hreq;
		for (int i = 0; i < 20 && hreq_o !== 1'b1; i++)
			tick(1);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial
	begin
		void'($urandom(24));
		tick(3);
		rst_i <= 1'b0;
		chk({hreq_o, io_first_o, mem_first_o, served_chan_o, grant_o}, 32'h0);
		rd(ADR_STATUS, 32'h1);
		rd(ADR_CTRL, 32'h0);
		rd(ADR_MASK, 32'hF);
		rd(ADR_SWREQ, 32'h0);
		rd(ADR_MODE_BASE + 8'h0C, 32'h0);
		wr(8'h40, $urandom());
		rd(8'h40, 32'h0);
		dreq <= 4'hF;
		tick(4);
		chk(hreq_o, 1'b0);
		dreq <= 4'h0;
		wr(ADR_MASK, 32'h0);
		dreq <= 4'h2;
		wait_hreq();
		chk({served_chan_o, grant_o}, 32'h12);
		wr(ADR_MODE_BASE + 8'h04, 32'h04);
		rd(ADR_MODE_BASE + 8'h04, 32'h04);
		rd(ADR_STATUS, 32'h0002_0112);
		dreq <= 4'hA;
		tick(2);
		dreq <= 4'h8;
		tick(3);
		chk({hreq_o, served_chan_o}, 32'h7);
		dreq <= 4'h0;
		tick(3);
		chk(hreq_o, 1'b0);
		dreq <= 4'h8;
		wait_hreq();
		wr(ADR_MODE_BASE + 8'h0C, {24'h0, MODE_TYPE_CASCADE, 6'h0});
		tick(2);
		chk(hreq_o, 1'b0);
		rd(ADR_STATUS, 32'h1);
		wr(ADR_MODE_BASE + 8'h0C, 32'h0);
		reach(4'h2, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h100, 4'h3);
		tick(2);
		chk(io_first_o, 1'b1);
		finish();
		wr(ADR_MODE_BASE + 8'h08, 32'h01);
		reach(4'h4, 1'b1);
		finish();
		wr(ADR_MODE_BASE + 8'h08, 32'h00);
		wr(ADR_CTRL, 32'h3);
		reach(4'h1, 1'b1);
		finish();
		reach(4'h2, 1'b0);
		finish();
		reach(4'h3, 1'b1);
		finish();
		wr(ADR_CTRL, 32'h1);
		reach(4'h1, 1'b0);
		finish();
		reach(4'h2, 1'b0);
		dreq <= 4'h0;
		hen <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h101, 4'h3);
		tick(2);
		chk({hreq_o, io_first_o}, 32'h0);
		reach(4'h4, 1'b0);
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		dreq <= 4'h0;
		hen <= 1'b0;
		chk({hreq_o, io_first_o, mem_first_o, served_chan_o, grant_o}, 32'h0);
		rd(ADR_STATUS, 32'h1);
		rd(ADR_MASK, 32'hF);
		end_sim();
	end
endmodule

// ### verif/hold_host_model.sv
// host side of the hold handshake: grants the bus after a chosen delay
`timescale 1ns/1ps
module hold_host_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hreq_i,
	input wire logic en_i,
	input wire logic [3:0] dly_i,
	output logic hlda_o
);
	logic [3:0] cnt_r;

	// --------------------------------------------------------
	// grant logic
	// --------------------------------------------------------
	// a disabled host never grants, so the device can be held in acquire
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !hreq_i)
		begin
			cnt_r <= 4'h0;
			hlda_o <= 1'b0;
		end
		else if (en_i && cnt_r >= dly_i)
			hlda_o <= 1'b1;
		else if (en_i)
			cnt_r <= cnt_r + 4'h1;
	end
endmodule
